// File: design/serial_card.sv
`include "serial_card_defines.svh"

module serial_card #(
	parameter bit CHAN2 = 1'b0
) (
	// clock, reset, enable
	input  wire logic                   ref_clk_i,
	input  wire logic                   resetn_i,
	input  wire logic                   ce_i,
	// register port
	input  wire serial_card_pkg::bus_t  bus_i,
	output      logic [7:0]             rd_data_o,
	// transfer engines
	input  wire logic                   xfer_wr_i,
	input  wire logic [7:0]             xfer_data_i,
	input  wire logic                   xfer_rd_i,
	output      logic [7:0]             xfer_data_o,
	output      serial_card_pkg::trig_t dma_trig_o,
	output      serial_card_pkg::trig_t xfer_trig_o,
	// interrupt lines
	output      serial_card_pkg::req_t  req_o,
	output      logic                   irq_o,
	// serial pins
	input  wire logic                   rxd_i,
	output      logic                   txd_o
);
	import serial_card_pkg::*;

	state_t     s;
	state_t     next;
	logic       n8;
	logic       pen;
	logic       odd;
	logic [3:0] nbits;
	logic [7:0] d;
	logic [7:0] line;
	logic       pbit;
	logic [3:0] reqv;
	logic [10:0] f;

	// ****************************************************************
	// helpers
	// ****************************************************************

	// data shaping, same both ways since reverse and invert undo
	function automatic logic [7:0] shape(input logic [7:0] v, input logic len8,
		input logic dir, input logic inv);
		logic [7:0] r;
		r = v;
		if (len8 && dir) begin
			for (int i = 0; i < 8; i++) begin
				r[i] = v[7 - i];
			end
		end
		if (inv) begin
			r = ~r;
		end
		if (!len8) begin
			r[7] = 1'b0;
		end
		return r;
	endfunction

	// parity bit over line data, sense from odd select only
	function automatic logic parity(input logic [7:0] v, input logic o);
		return ^v ^ o;
	endfunction

	// ****************************************************************
	// next state
	// ****************************************************************

	// all state derived in one place
	always_comb begin
		next  = s;
		n8    = !s.mode[`MOD_LEN7] || s.card_if;
		pen   = s.mode[`MOD_PEN] || s.card_if;
		odd   = s.mode[`MOD_ODD];
		nbits = n8 ? 4'h8 : 4'h7;
		d     = 8'h00;
		line  = 8'h00;
		pbit  = 1'b0;
		f     = 11'h7FF;
		reqv  = 4'h0;

		// pin synchroniser, level taken once stages two and three agree
		next.sync = {s.sync[1:0], rxd_i};
		if (s.sync[1] == s.sync[2]) begin
			next.rx_lvl = s.sync[2];
		end

		// transmitter, ahead of bus writes so a fresh write stays pending
		unique case (s.tx_st)
			TX_IDLE: begin
				if (s.ctrl[`CTL_TX_EN] && !s.empty_f) begin
					d = shape(s.tx_buf, n8, s.bit_order, s.invert);
					f[0] = 1'b0;
					for (int i = 0; i < 8; i++) begin
						if (i < int'(nbits)) begin
							f[i + 1] = d[i];
						end
					end
					if (pen) begin
						f[nbits + 4'h1] = parity(d, odd);
					end
					next.tx_sh   = f;
					next.tx_left = nbits + {3'h0, pen} + 4'h2;
					next.tx_cnt  = s.div;
					next.tx_st   = TX_SEND;
					next.empty_f = 1'b1;
				end
			end
			TX_SEND: begin
				if (s.tx_cnt == 8'h00) begin
					next.tx_cnt  = s.div;
					next.tx_sh   = {1'b1, s.tx_sh[10:1]};
					next.tx_left = s.tx_left - 4'h1;
					if (s.tx_left == 4'h1) begin
						next.tx_st  = TX_IDLE;
						next.done_f = s.empty_f;
					end
				end else begin
					next.tx_cnt = s.tx_cnt - 8'h01;
				end
			end
		endcase

		// register writes
		if (bus_i.wr) begin
			case (bus_i.addr)
				`A_MODE: next.mode = bus_i.wdata;
				`A_CTRL: next.ctrl = bus_i.wdata;
				`A_DIV:  next.div  = bus_i.wdata;
				`A_MASK: next.mask = bus_i.wdata[3:0];
				`A_TX_BUF: begin
					next.tx_buf  = bus_i.wdata;
					next.empty_f = 1'b0;
					next.done_f  = 1'b0;
				end
				`A_STATUS: begin
					if (bus_i.wdata[`ST_OVR]) next.ovr_f = 1'b0;
					if (bus_i.wdata[`ST_FRM]) next.frm_f = 1'b0;
					if (bus_i.wdata[`ST_PAR]) next.par_f = 1'b0;
				end
				`A_CARD: begin
					next.bit_order = bus_i.wdata[`CD_DIR];
					next.invert    = bus_i.wdata[`CD_INV];
					next.card_if   = bus_i.wdata[`CD_SIF];
				end
				`A_EVENT: next.ev = s.ev & ~bus_i.wdata[3:0];
				default: ;
			endcase
		end

		// transfer engine write fills the buffer and clears empty
		if (xfer_wr_i) begin
			next.tx_buf  = xfer_data_i;
			next.empty_f = 1'b0;
			next.done_f  = 1'b0;
		end

		// register reads, data stand only in the following cycle
		next.rd_data = 8'h00;
		if (bus_i.rd) begin
			case (bus_i.addr)
				`A_MODE:   next.rd_data = s.mode;
				`A_CTRL:   next.rd_data = s.ctrl;
				`A_DIV:    next.rd_data = s.div;
				`A_TX_BUF: next.rd_data = s.tx_buf;
				`A_EVENT:  next.rd_data = {4'h0, s.ev};
				`A_MASK:   next.rd_data = {4'h0, s.mask};
				`A_STATUS: next.rd_data = {s.empty_f, s.full_f, s.ovr_f, s.frm_f,
					s.par_f, s.done_f, 2'b00};
				`A_CARD:   next.rd_data = {4'h0, s.bit_order, s.invert, `RST_RSV,
					s.card_if};
				`A_RX_BUF: begin
					next.rd_data = s.rx_buf;
					next.full_f  = 1'b0;
				end
				default: next.rd_data = 8'h00;
			endcase
		end

		// transfer engine read empties the buffer
		if (xfer_rd_i) begin
			next.full_f = 1'b0;
		end

		// receiver, after the clears so a new frame's flags win
		unique case (s.rx_st)
			RX_IDLE: begin
				if (s.ctrl[`CTL_RX_EN] && !s.rx_lvl) begin
					next.rx_st  = RX_START;
					next.rx_cnt = {1'b0, s.div[7:1]};
				end
			end
			RX_START: begin
				if (s.rx_cnt == 8'h00) begin
					next.rx_cnt = s.div;
					next.rx_idx = 4'h0;
					next.rx_st  = s.rx_lvl ? RX_IDLE : RX_DATA;
				end else begin
					next.rx_cnt = s.rx_cnt - 8'h01;
				end
			end
			RX_DATA: begin
				if (s.rx_cnt == 8'h00) begin
					next.rx_cnt = s.div;
					if (s.rx_idx == nbits + {3'h0, pen}) begin
						line = n8 ? s.rx_sh[7:0] : {1'b0, s.rx_sh[6:0]};
						pbit = s.rx_sh[nbits];
						next.rx_st = RX_IDLE;
						if (!s.rx_lvl) begin
							next.frm_f = 1'b1;
						end
						if (pen && (parity(line, odd) != pbit)) begin
							next.par_f = 1'b1;
						end
						if (s.full_f) begin
							next.ovr_f = 1'b1;
						end else begin
							next.rx_buf = shape(line, n8, s.bit_order, s.invert);
							next.full_f = 1'b1;
						end
					end else begin
						next.rx_sh[s.rx_idx] = s.rx_lvl;
						next.rx_idx = s.rx_idx + 4'h1;
					end
				end else begin
					next.rx_cnt = s.rx_cnt - 8'h01;
				end
			end
		endcase
		if (!s.ctrl[`CTL_RX_EN]) begin
			next.rx_st = RX_IDLE;
		end
		next.txd = (next.tx_st == TX_SEND) ? next.tx_sh[0] : 1'b1;

		// request lines, each its flag gated by an enable, rx full and rx error sharing the rx enable
		next.req.tx_empty = s.empty_f && s.ctrl[`CTL_TX_IE];
		next.req.tx_end   = s.done_f && s.ctrl[`CTL_END_IE];
		next.req.rx_full  = s.full_f && s.ctrl[`CTL_RX_IE];
		next.req.rx_err   = (s.ovr_f || s.frm_f || s.par_f) && s.ctrl[`CTL_RX_IE];
		reqv = next.req;

		// only data requests start transfers, dma never on channel two
		next.xfer.tx_empty = next.req.tx_empty;
		next.xfer.rx_full  = next.req.rx_full;
		next.dma.tx_empty  = next.req.tx_empty && !CHAN2;
		next.dma.rx_full   = next.req.rx_full && !CHAN2;

		// sticky events on a rising request, set beats the clear
		next.ev  = next.ev | (reqv & ~s.req);
		next.irq = |(next.ev & next.mask);
	end

	// ****************************************************************
	// state register
	// ****************************************************************

	// state held while the enable is low
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s         <= '0;
			s.div     <= `RST_DIV;
			s.empty_f <= 1'b1;
			s.done_f  <= 1'b1;
			s.sync    <= 3'h7;
			s.rx_lvl  <= 1'b1;
			s.txd     <= 1'b1;
			s.tx_st   <= TX_IDLE;
			s.rx_st   <= RX_IDLE;
		end else if (ce_i) begin
			s <= next;
		end
	end

	// outputs straight from state
	assign rd_data_o   = s.rd_data;
	assign xfer_data_o = s.rx_buf;
	assign dma_trig_o  = s.dma;
	assign xfer_trig_o = s.xfer;
	assign req_o       = s.req;
	assign irq_o       = s.irq;
	assign txd_o       = s.txd;

	// ****************************************************************
	// checks
	// ****************************************************************

	tx_empty_req_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		ce_i && s.empty_f && s.ctrl[`CTL_TX_IE] |=> req_o.tx_empty)
		else $error("tx empty request missing");
	tx_end_req_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		ce_i && s.done_f && s.ctrl[`CTL_END_IE] |=> req_o.tx_end)
		else $error("tx end request missing");
	rx_full_req_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		ce_i && s.full_f && s.ctrl[`CTL_RX_IE] |=> req_o.rx_full)
		else $error("rx full request missing");
	rx_err_req_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		ce_i && (s.ovr_f || s.frm_f || s.par_f) && s.ctrl[`CTL_RX_IE] |=> req_o.rx_err)
		else $error("rx error request missing");
	req_drop_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		ce_i && !(s.empty_f && s.ctrl[`CTL_TX_IE]) |=> !req_o.tx_empty)
		else $error("tx empty request held without cause");
	trig_source_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(xfer_trig_o.tx_empty || dma_trig_o.tx_empty) |-> req_o.tx_empty)
		else $error("transfer started without tx empty request");
	chan_two_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		CHAN2 |-> !dma_trig_o.tx_empty && !dma_trig_o.rx_full)
		else $error("dma started on channel two");
	xfer_clear_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		ce_i && xfer_wr_i |=> !s.empty_f)
		else $error("transfer write left empty flag set");
	rsvd_read_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		ce_i && bus_i.rd && bus_i.addr == `A_CARD |=> rd_data_o[`CD_RSV])
		else $error("reserved card bit read as zero");
	irq_out_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$rose(req_o.rx_full) && s.mask[1] |-> irq_o)
		else $error("masked-in event gave no interrupt");

	// ****************************************************************
	// request drop, event, interrupt, read, line and freeze checks
	// ****************************************************************

	// rx full request falls with its flag or enable
	rx_full_drop_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		ce_i && !(s.full_f && s.ctrl[`CTL_RX_IE]) |=> !req_o.rx_full)
		else $error("rx full request held without cause");

	// tx end request falls with its flag or enable
	tx_end_drop_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		ce_i && !(s.done_f && s.ctrl[`CTL_END_IE]) |=> !req_o.tx_end)
		else $error("tx end request held without cause");

	// rx error request falls once all error flags are clear
	rx_err_drop_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		ce_i && !((s.ovr_f || s.frm_f || s.par_f) && s.ctrl[`CTL_RX_IE]) |=> !req_o.rx_err)
		else $error("rx error request held without cause");

	// receive transfers only ever come from the rx full request
	rx_trig_src_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(xfer_trig_o.rx_full || dma_trig_o.rx_full) |-> req_o.rx_full)
		else $error("transfer started without rx full request");

	// transfer read clears full unless a frame lands at once
	rd_clear_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		ce_i && xfer_rd_i && s.rx_st != RX_DATA |=> !s.full_f)
		else $error("transfer read left full flag set");

	// a rising tx empty request always leaves its sticky event bit set
	ev_empty_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$rose(req_o.tx_empty) |-> s.ev[0])
		else $error("tx empty event not recorded");

	// same for the receive error request
	ev_err_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$rose(req_o.rx_err) |-> s.ev[2])
		else $error("rx error event not recorded");

	// same for the transmit end request
	ev_end_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$rose(req_o.tx_end) |-> s.ev[3])
		else $error("tx end event not recorded");

	// interrupt line follows event and mask on the same edge
	irq_level_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		ce_i |=> irq_o == |(s.ev & s.mask))
		else $error("interrupt line disagrees with events");

	// read data return to zero when no read was made
	rd_idle_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		ce_i && !bus_i.rd |=> rd_data_o == 8'h00)
		else $error("read data left standing");

	// an idle transmitter keeps the line high
	line_idle_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		s.tx_st == TX_IDLE |-> txd_o)
		else $error("line low while transmitter idle");

	// a loaded buffer starts a frame with a low start bit
	tx_start_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		ce_i && s.tx_st == TX_IDLE && s.ctrl[`CTL_TX_EN] && !s.empty_f && !xfer_wr_i &&
		!(bus_i.wr && bus_i.addr == `A_TX_BUF) |=> !txd_o && s.empty_f)
		else $error("loaded frame did not start");

	// low enable freezes every bit of state
	freeze_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		!ce_i |=> $stable(s))
		else $error("state moved while enable low");
endmodule

// File: design/serial_card_defines.svh
`ifndef SERIAL_CARD_DEFINES_SVH
`define SERIAL_CARD_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define A_MODE     4'h0
`define A_CTRL     4'h1
`define A_STATUS   4'h2
`define A_TX_BUF   4'h3
`define A_RX_BUF   4'h4
`define A_CARD     4'h5
`define A_DIV      4'h6
`define A_EVENT    4'h7
`define A_MASK     4'h8

// ****************************************************************
// field positions
// ****************************************************************
`define MOD_LEN7   6
`define MOD_PEN    5
`define MOD_ODD    4
`define CTL_TX_IE  7
`define CTL_RX_IE  6
`define CTL_TX_EN  5
`define CTL_RX_EN  4
`define CTL_END_IE 2
`define ST_EMPTY   7
`define ST_FULL    6
`define ST_OVR     5
`define ST_FRM     4
`define ST_PAR     3
`define ST_DONE    2
`define CD_DIR     3
`define CD_INV     2
`define CD_RSV     1
`define CD_SIF     0

// ****************************************************************
// reset values and timing
// ****************************************************************
`define RST_DIV    8'h0F
`define RST_RSV    1'b1
`endif

// File: design/serial_card_pkg.sv
package serial_card_pkg;
	// one bit per request line
	typedef struct packed {
		logic tx_end;
		logic rx_err;
		logic rx_full;
		logic tx_empty;
	} req_t;

	// transfer start lines
	typedef struct packed {
		logic tx_empty;
		logic rx_full;
	} trig_t;

	// register port
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_t;

	typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} tx_st_t;
	typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_START = 3'b010, RX_DATA = 3'b100} rx_st_t;

	typedef struct packed {
		logic [7:0]  mode;
		logic [7:0]  ctrl;
		logic [7:0]  div;
		logic [7:0]  tx_buf;
		logic [7:0]  rx_buf;
		logic [7:0]  rd_data;
		logic        bit_order;
		logic        invert;
		logic        card_if;
		logic        empty_f;
		logic        done_f;
		logic        full_f;
		logic        ovr_f;
		logic        frm_f;
		logic        par_f;
		logic [3:0]  ev;
		logic [3:0]  mask;
		logic        irq;
		req_t        req;
		trig_t       dma;
		trig_t       xfer;
		logic [2:0]  sync;
		logic        rx_lvl;
		tx_st_t      tx_st;
		logic [7:0]  tx_cnt;
		logic [3:0]  tx_left;
		logic [10:0] tx_sh;
		logic        txd;
		rx_st_t      rx_st;
		logic [7:0]  rx_cnt;
		logic [3:0]  rx_idx;
		logic [9:0]  rx_sh;
	} state_t;
endpackage

// File: sim/serial_peer.sv
module serial_peer #(
	parameter int BIT_CYC = 8
) (
	// clock and serial pins
	input  wire logic clk_i,
	input  wire logic txd_i,
	output      logic rxd_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// released line rests high, like a pull-up
	initial rxd_o = 1'b1;

	// drive line bits first to last, one bit time each
	task automatic send(input logic [10:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			rxd_o <= bits[i];
			repeat (BIT_CYC - 1) @(posedge clk_i);
		end
		@(posedge clk_i);
		rxd_o <= 1'b1;
	endtask

	// wait for a start edge, then sample each bit at its middle
	task automatic get(input int n, output logic [10:0] bits);
		bits = 11'h000;
		@(negedge txd_i);
		repeat (BIT_CYC / 2) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			bits[i] = txd_i;
			repeat (BIT_CYC) @(posedge clk_i);
		end
	endtask
endmodule

// File: sim/tb_serial_card.sv
`include "serial_card_defines.svh"

module tb_serial_card;
	timeunit 1ns;
	timeprecision 1ps;
	import serial_card_pkg::*;

	// format cases: {card, order, invert, len7, parity, odd}
	localparam logic [5:0] CASES [6] = '{6'h10, 6'h08, 6'h14, 6'h0B, 6'h13, 6'h24};

	logic        ref_clk_i;
	logic        resetn_i;
	logic        xfer_wr;
	logic        xfer_rd;
	logic        rxd;
	logic        txd;
	logic        irq;
	logic [7:0]  rd_data;
	logic [7:0]  xfer_wdata;
	logic [7:0]  xfer_rdata;
	bus_t        bus;
	req_t        req;
	trig_t       dma_trig;
	trig_t       xfer_trig;
	trig_t       dma_trig2;
	int          err_total;
	int          n_compared;

	// ****************************************************************
	// design, channel-two copy and serial peer
	// ****************************************************************
	serial_card #(.CHAN2(1'b0)) i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
		.bus_i(bus), .rd_data_o(rd_data), .xfer_wr_i(xfer_wr), .xfer_data_i(xfer_wdata),
		.xfer_rd_i(xfer_rd), .xfer_data_o(xfer_rdata), .dma_trig_o(dma_trig),
		.xfer_trig_o(xfer_trig), .req_o(req), .irq_o(irq), .rxd_i(rxd), .txd_o(txd));
	serial_card #(.CHAN2(1'b1)) i_dut2 (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
		.bus_i(bus), .rd_data_o(), .xfer_wr_i(xfer_wr), .xfer_data_i(xfer_wdata),
		.xfer_rd_i(xfer_rd), .xfer_data_o(), .dma_trig_o(dma_trig2),
		.xfer_trig_o(), .req_o(), .irq_o(), .rxd_i(rxd), .txd_o());
	serial_peer #(.BIT_CYC(8)) i_peer (.clk_i(ref_clk_i), .txd_i(txd), .rxd_o(rxd));

	// 25 MHz clock
	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	// line bits of one frame, start bit at index zero
	function automatic logic [10:0] frame(input logic [7:0] d, input logic [5:0] f);
		logic [10:0] b;
		logic        len7;
		logic        p;
		int          n;
		len7 = f[2] & ~f[5];
		b = 11'h000;
		p = f[0];
		n = 1;
		for (int i = 0; i < 8 - int'(len7); i++) begin
			b[n] = f[3] ^ ((f[4] && !len7) ? d[7 - i] : d[i]);
			p = p ^ b[n];
			n++;
		end
		if (f[1] | f[5]) begin
			b[n] = p;
			n++;
		end
		b[n] = 1'b1;
		return b;
	endfunction

	function automatic int nbits(input logic [5:0] f);
		return 10 - int'(f[2] & ~f[5]) + int'(f[1] | f[5]);
	endfunction

	task automatic check(input logic [10:0] seen, input logic [10:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk_i);
		bus.wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge ref_clk_i);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk_i);
		bus.rd <= 1'b0;
		#1;
		check(11'(rd_data), 11'(exp));
	endtask

	task automatic t_regs();
		rd(`A_CARD, 8'h02);
		rd(`A_STATUS, 8'h84);
		rd(`A_DIV, 8'h0F);
		wr(`A_CARD, 8'hFF);
		rd(`A_CARD, 8'h0F);
		wr(`A_CARD, 8'h00);
		rd(`A_CARD, 8'h02);
		rd(4'hF, 8'h00);
		wr(`A_DIV, 8'h07);
		$display("test regs done");
	endtask

	task automatic t_irq();
		logic [10:0] got;
		wr(`A_CTRL, 8'h84);
		tick(2);
		check(11'(req), 11'h009);
		check(11'({dma_trig, xfer_trig, dma_trig2}), 11'h028);
		wr(`A_CTRL, 8'h04);
		tick(2);
		check(11'(req), 11'h008);
		wr(`A_CTRL, 8'h84);
		rd(`A_EVENT, 8'h09);
		wr(`A_MASK, 8'h01);
		tick(2);
		check(11'(irq), 11'h001);
		wr(`A_EVENT, 8'h01);
		tick(2);
		check(11'(irq), 11'h000);
		wr(`A_MASK, 8'h08);
		tick(2);
		check(11'(irq), 11'h001);
		wr(`A_MASK, 8'h00);
		tick(2);
		check(11'(irq), 11'h000);
		// transfer engine fills the buffer while the transmitter is off
		@(posedge ref_clk_i);
		xfer_wr <= 1'b1;
		xfer_wdata <= 8'h2D;
		@(posedge ref_clk_i);
		xfer_wr <= 1'b0;
		tick(2);
		check(11'(req), 11'h000);
		check(11'(xfer_trig), 11'h000);
		fork
			i_peer.get(10, got);
			wr(`A_CTRL, 8'hA0);
		join
		check(got, frame(8'h2D, 6'h00));
		tick(24);
		$display("test irq done");
	endtask

	task automatic t_tx();
		logic [10:0] got;
		logic [5:0]  f;
		for (int k = 0; k < 6; k++) begin
			f = CASES[k];
			wr(`A_MODE, {1'b0, f[2:0], 4'h0});
			wr(`A_CARD, {4'h0, f[4:3], 1'b0, f[5]});
			fork
				i_peer.get(nbits(f), got);
				wr(`A_TX_BUF, 8'hB4 + 8'(k));
			join
			check(got, frame(8'hB4 + 8'(k), f));
			tick(24);
		end
		$display("test tx done");
	endtask

	task automatic t_rx();
		wr(`A_MODE, 8'h00);
		wr(`A_CARD, 8'h0C);
		wr(`A_CTRL, 8'h50);
		wr(`A_MASK, 8'h02);
		i_peer.send(frame(8'h1E, 6'h00), 10);
		tick(8);
		check(11'(req), 11'h002);
		check(11'(irq), 11'h001);
		check(11'({xfer_trig, xfer_rdata}), 11'h187);
		@(posedge ref_clk_i);
		xfer_rd <= 1'b1;
		@(posedge ref_clk_i);
		xfer_rd <= 1'b0;
		tick(2);
		check(11'(req), 11'h000);
		// stop bit held low gives a framing error
		i_peer.send(frame(8'h55, 6'h00) & 11'h1FF, 10);
		tick(8);
		check(11'(req.rx_err), 11'h001);
		tick(100);
		wr(`A_STATUS, 8'h38);
		tick(2);
		check(11'(req.rx_err), 11'h000);
		$display("test rx done");
	endtask

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// main sequence
	initial begin
		bus = '0;
		xfer_wr = 1'b0;
		xfer_rd = 1'b0;
		xfer_wdata = 8'h00;
		err_total = 0;
		n_compared = 0;
		resetn_i = 1'b0;
		repeat (12) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		t_regs();
		t_irq();
		t_tx();
		t_rx();
		results();
	end

	// watchdog, well past the roughly 1200 cycles the tests need
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		err_total++;
		results();
	end
endmodule
